/* File: src/dbgst_pkg.sv */
`default_nettype none
package dbgst_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_RESET_REQ = 8'h08;
  localparam logic [7:0] IDX_SYS_CTRL = 8'h0a;
  localparam logic [7:0] IDX_SYS_STATUS = 8'h0b;
  localparam logic [7:0] IDX_CRC_STATUS = 8'h0c;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;

  // System control fields
  localparam int CTRL_CLK_REQ_BIT = 0;
  localparam int CTRL_UROW_DONE_BIT = 1;
  localparam logic CLK_REQ_DEFAULT = 1'b1;
  localparam logic UROW_DONE_RST = 1'b0;

  // System status fields
  localparam int STAT_BOOT_ERASE_BIT = 7;
  localparam int STAT_ERASE_FAIL_BIT = 6;
  localparam int STAT_RST_ACTIVE_BIT = 5;
  localparam int STAT_SLEEP_BIT = 4;
  localparam int STAT_PROG_BIT = 3;
  localparam int STAT_UROW_BIT = 2;
  localparam int STAT_BOOT_BIT = 1;
  localparam int STAT_LOCK_BIT = 0;
  localparam logic [7:0] SYS_STATUS_RST = 8'h01;

  // Reset request signatures
  localparam logic [7:0] RESET_REQ_RST = 8'h00;
  localparam logic [7:0] RST_SIG_RESET = 8'h59;
  localparam logic [7:0] RST_SIG_RUN = 8'h00;

  // CRC status codes
  localparam logic [2:0] CRC_CODE_OFF = 3'h0;
  localparam logic [2:0] CRC_CODE_BUSY = 3'h1;
  localparam logic [2:0] CRC_CODE_OK = 3'h2;
  localparam logic [2:0] CRC_CODE_FAIL = 3'h4;
  localparam logic [7:0] CRC_STATUS_RST = 8'h00;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    CRC_ST_OFF = 4'h1,
    CRC_ST_BUSY = 4'h2,
    CRC_ST_OK = 4'h4,
    CRC_ST_FAIL = 4'h8
  } dbgst_crc_state_t;

  function automatic logic [3:0] dbgst_word_idx(input logic [ADDR_W-1:0] addr);
    return addr[5:2];
  endfunction

  function automatic logic dbgst_is_mapped(input logic [3:0] idx);
    return (idx == IDX_RESET_REQ[3:0]) || (idx == IDX_SYS_CTRL[3:0]) ||
           (idx == IDX_SYS_STATUS[3:0]) || (idx == IDX_CRC_STATUS[3:0]);
  endfunction

endpackage
`default_nettype wire

/* File: src/dbgst_crc_status.sv */
`timescale 1ns/1ps
`default_nettype none
module dbgst_crc_status import dbgst_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // CRC engine state
  input wire logic crc_enabled,
  input wire logic crc_done,
  input wire logic crc_pass,
  // Status field
  output logic [2:0] crc_field
);

  dbgst_crc_state_t state_r;
  dbgst_crc_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CRC_ST_OFF: state_nxt = CRC_ST_BUSY;
      CRC_ST_BUSY: begin
        if (crc_done) begin
          state_nxt = crc_pass ? CRC_ST_OK : CRC_ST_FAIL;
        end
      end
      CRC_ST_OK: state_nxt = CRC_ST_OK;
      CRC_ST_FAIL: state_nxt = CRC_ST_FAIL;
      default: state_nxt = CRC_ST_OFF;
    endcase
    if (!crc_enabled) begin
      state_nxt = CRC_ST_OFF;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= CRC_ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // One-hot field straight from the state flops
  assign crc_field = (state_r == CRC_ST_BUSY) ? CRC_CODE_BUSY :
                     (state_r == CRC_ST_OK) ? CRC_CODE_OK :
                     (state_r == CRC_ST_FAIL) ? CRC_CODE_FAIL : CRC_CODE_OFF;

endmodule
`default_nettype wire

/* File: src/dbgst_status_flags.sv */
`timescale 1ns/1ps
`default_nettype none
module dbgst_status_flags import dbgst_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // System side
  input wire logic sys_reset_seen,
  input wire logic [2:0] sys_sleep_mode,
  input wire logic cpu_boot_done,
  input wire logic erase_fail_evt,
  input wire logic nvm_prog_ok,
  input wire logic userrow_prog_ok,
  input wire logic nvm_lock_bits,
  // Side effect of a status read
  input wire logic status_read_clr,
  // Status byte
  output logic [7:0] status_r
);

  logic [7:0] status_nxt;
  logic erase_nxt;
  logic boot_nxt;

  // A pending event wins over a clear in the same cycle
  assign erase_nxt = erase_fail_evt | (status_r[STAT_ERASE_FAIL_BIT] & !sys_reset_seen);
  assign boot_nxt = cpu_boot_done | (status_r[STAT_BOOT_BIT] & !sys_reset_seen);

  always_comb begin
    status_nxt = status_r;
    status_nxt[STAT_ERASE_FAIL_BIT] = erase_nxt;
    status_nxt[STAT_BOOT_BIT] = boot_nxt;
    status_nxt[STAT_BOOT_ERASE_BIT] = erase_nxt | boot_nxt;
    status_nxt[STAT_RST_ACTIVE_BIT] = sys_reset_seen | (status_r[STAT_RST_ACTIVE_BIT] & !status_read_clr);
    status_nxt[STAT_SLEEP_BIT] = (sys_sleep_mode != 3'h0);
    status_nxt[STAT_PROG_BIT] = nvm_prog_ok;
    status_nxt[STAT_UROW_BIT] = userrow_prog_ok;
    status_nxt[STAT_LOCK_BIT] = nvm_lock_bits;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_r <= SYS_STATUS_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

endmodule
`default_nettype wire

/* File: src/dbgst_top.sv */
// Notes on behaviour
// - Clock request held high while bit set; the code raises it only while dbg_enable is also high
// - Writing zero drops the clock request
// - Clock request defaults high on enable
// - Bit 7 is erase-failed OR boot-complete
// - Erase-failed set on failure, cleared by reset
// - Reset-active reads one during system reset
// - Reading status clears the reset-active flag
// - Sleep flag high in idle or deeper
// - Bit 3 shows NVM programming may start
// - Bit 2 shows user row programming may start
// - Boot-complete set when CPU boot ends
// - No bridge access before boot completes
// - Lock flag follows device lock state
// - CRC field zero when CRC disabled
// - CRC field one-hot busy, pass, fail
// - Status resets to 0x01, all read-only
// - 0x59 holds system reset, 0x00 releases
// - User-row-done starts programming, needs key
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module dbgst_top import dbgst_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Debug side state
  input wire logic dbg_enable,
  input wire logic userrow_key_ok,
  // System side state
  input wire logic sys_in_reset,
  input wire logic [2:0] sys_sleep_mode,
  input wire logic cpu_boot_done,
  input wire logic erase_fail_evt,
  input wire logic nvm_prog_ok,
  input wire logic userrow_prog_ok,
  input wire logic nvm_lock_bits,
  // CRC engine state
  input wire logic crc_enabled,
  input wire logic crc_done,
  input wire logic crc_pass,
  // Requests toward the system
  output logic sys_clock_request,
  output logic sys_reset_hold,
  output logic userrow_prog_start,
  output logic bridge_access_allow
);

  // Write channel capture
  logic aw_got_r;
  logic w_got_r;
  logic [ADDR_W-1:0] awaddr_q_r;
  logic [DATA_W-1:0] wdata_q_r;
  logic [3:0] wstrb_q_r;

  // Software-visible control state
  logic clk_req_r;
  logic urow_done_r;
  logic [7:0] reset_req_r;

  // Status sources
  logic [7:0] sys_status;
  logic [2:0] crc_field;

  // Write decode
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire wr_go = aw_got_r & w_got_r & !s_axi_bvalid;
  wire [3:0] wr_idx = dbgst_word_idx(awaddr_q_r);
  wire wr_mapped = dbgst_is_mapped(wr_idx);
  wire wr_lane0 = wr_go & wstrb_q_r[0];
  wire wr_ctrl = wr_lane0 & (wr_idx == IDX_SYS_CTRL[3:0]);
  wire wr_rstreq = wr_lane0 & (wr_idx == IDX_RESET_REQ[3:0]);
  wire [7:0] wr_byte = wdata_q_r[7:0];
  wire wr_sig_reset = wr_rstreq & (wr_byte == RST_SIG_RESET);
  wire wr_sig_run = wr_rstreq & (wr_byte == RST_SIG_RUN);
  wire wr_urow_ok = wr_ctrl & userrow_key_ok;

  // Read decode
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  wire r_hs = s_axi_rvalid & s_axi_rready;
  wire [3:0] rd_idx = dbgst_word_idx(s_axi_araddr);
  wire rd_mapped = dbgst_is_mapped(rd_idx);
  wire rd_status = ar_hs & (rd_idx == IDX_SYS_STATUS[3:0]);
  wire [7:0] ctrl_byte = {6'h00, urow_done_r, clk_req_r};
  wire [7:0] rd_byte = (rd_idx == IDX_RESET_REQ[3:0]) ? reset_req_r :
                       (rd_idx == IDX_SYS_CTRL[3:0]) ? ctrl_byte :
                       (rd_idx == IDX_SYS_STATUS[3:0]) ? sys_status :
                       (rd_idx == IDX_CRC_STATUS[3:0]) ? {5'h00, crc_field} : 8'h00;

  // A reset held from the request register counts as a system reset
  wire sys_reset_seen = sys_in_reset | sys_reset_hold;

  // Clock request toward the system clock controller
  wire clk_req_nxt = !dbg_enable ? CLK_REQ_DEFAULT :
                     wr_ctrl ? wr_byte[CTRL_CLK_REQ_BIT] : clk_req_r;

  // Reset hold: reserved values keep the current hold state
  wire hold_nxt = wr_sig_reset ? 1'b1 : (wr_sig_run ? 1'b0 : sys_reset_hold);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_got_r <= 1'b0;
      awaddr_q_r <= '0;
    end else if (aw_hs) begin
      aw_got_r <= 1'b1;
      awaddr_q_r <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_got_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      w_got_r <= 1'b0;
      wdata_q_r <= '0;
      wstrb_q_r <= '0;
    end else if (w_hs) begin
      w_got_r <= 1'b1;
      wdata_q_r <= s_axi_wdata;
      wstrb_q_r <= s_axi_wstrb;
    end else if (wr_go) begin
      w_got_r <= 1'b0;
    end
  end

  // Ready drops once a beat is held, so one write at a time is in flight
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_got_r & !aw_hs & !s_axi_bvalid & !wr_go;
      s_axi_wready <= !w_got_r & !w_hs & !s_axi_bvalid & !wr_go;
    end
  end

  // Status and CRC registers take no write state at all
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bvalid & s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (r_hs) begin
      s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_req_r <= CLK_REQ_DEFAULT;
      sys_clock_request <= 1'b0;
    end else begin
      clk_req_r <= clk_req_nxt;
      sys_clock_request <= dbg_enable & clk_req_r;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reset_req_r <= RESET_REQ_RST;
      sys_reset_hold <= 1'b0;
    end else begin
      reset_req_r <= wr_rstreq ? wr_byte : reset_req_r;
      sys_reset_hold <= hold_nxt;
    end
  end

  // The done bit only moves once the user-row key is decoded
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      urow_done_r <= UROW_DONE_RST;
      userrow_prog_start <= 1'b0;
    end else begin
      urow_done_r <= wr_urow_ok ? wr_byte[CTRL_UROW_DONE_BIT] : urow_done_r;
      userrow_prog_start <= wr_urow_ok & wr_byte[CTRL_UROW_DONE_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bridge_access_allow <= 1'b0;
    end else begin
      bridge_access_allow <= sys_status[STAT_BOOT_BIT];
    end
  end

  dbgst_status_flags u_flags (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .sys_reset_seen(sys_reset_seen),
    .sys_sleep_mode(sys_sleep_mode),
    .cpu_boot_done(cpu_boot_done),
    .erase_fail_evt(erase_fail_evt),
    .nvm_prog_ok(nvm_prog_ok),
    .userrow_prog_ok(userrow_prog_ok),
    .nvm_lock_bits(nvm_lock_bits),
    .status_read_clr(rd_status),
    .status_r(sys_status)
  );

  dbgst_crc_status u_crc (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .crc_enabled(crc_enabled),
    .crc_done(crc_done),
    .crc_pass(crc_pass),
    .crc_field(crc_field)
  );

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  a_clk_req_default: assert property ($rose(dbg_enable) |-> ##1 sys_clock_request)
    else $error("clock request not raised on enable");

  a_clk_req_set: assert property ((wr_ctrl && dbg_enable && wr_byte[CTRL_CLK_REQ_BIT]) ##1
    (dbg_enable && !wr_ctrl) |=> sys_clock_request)
    else $error("clock request not held after write of one");

  a_clk_req_clear: assert property ((wr_ctrl && dbg_enable && !wr_byte[CTRL_CLK_REQ_BIT]) ##1
    dbg_enable |=> !sys_clock_request)
    else $error("clock request not lowered after write of zero");

  a_boot_erase_flag: assert property (sys_status[STAT_BOOT_ERASE_BIT] ==
    (sys_status[STAT_ERASE_FAIL_BIT] | sys_status[STAT_BOOT_BIT]))
    else $error("combined flag disagrees with its sources");

  a_erase_reset_clr: assert property ((sys_in_reset && !erase_fail_evt) |=>
    !sys_status[STAT_ERASE_FAIL_BIT])
    else $error("erase-failed flag survived a system reset");

  a_erase_set: assert property (erase_fail_evt |=> sys_status[STAT_ERASE_FAIL_BIT])
    else $error("erase failure not flagged");

  a_hold_rstact: assert property (wr_sig_reset |=> ##1 sys_status[STAT_RST_ACTIVE_BIT])
    else $error("held reset not reported as active");

  a_rstact_seen: assert property (sys_reset_seen |=> sys_status[STAT_RST_ACTIVE_BIT])
    else $error("reset-active low during a system reset");

  a_read_clears: assert property ((rd_status && !sys_reset_seen) |=>
    !sys_status[STAT_RST_ACTIVE_BIT])
    else $error("status read did not clear reset-active");

  a_prog_ready: assert property (nvm_prog_ok |=> sys_status[STAT_PROG_BIT])
    else $error("NVM programming ready flag missing");

  a_urow_ready: assert property (userrow_prog_ok |=> sys_status[STAT_UROW_BIT])
    else $error("user row ready flag missing");

  a_lock_follow: assert property (nvm_lock_bits |=> sys_status[STAT_LOCK_BIT])
    else $error("lock flag low while locked");

  a_lock_clear: assert property (!nvm_lock_bits |=> !sys_status[STAT_LOCK_BIT])
    else $error("lock flag high after unlock");

  a_sleep_flag: assert property ((sys_sleep_mode != 3'h0) |=> sys_status[STAT_SLEEP_BIT])
    else $error("sleep flag low while sleeping");

  a_boot_gate: assert property (!sys_status[STAT_BOOT_BIT] |=> !bridge_access_allow)
    else $error("bridge access granted before boot completed");

  a_boot_set: assert property (cpu_boot_done |=> ##1 bridge_access_allow)
    else $error("boot completion did not open the bridge");

  a_crc_off: assert property (!crc_enabled |=> (crc_field == CRC_CODE_OFF))
    else $error("CRC field nonzero while disabled");

  a_crc_onehot: assert property ($onehot0(crc_field))
    else $error("CRC field not one-hot");

  a_crc_busy: assert property ((crc_enabled && crc_field == CRC_CODE_OFF) |=> (crc_field == CRC_CODE_BUSY))
    else $error("CRC field not busy after enable");

  a_reset_hold: assert property (wr_sig_reset |=> sys_reset_hold)
    else $error("reset signature did not hold system reset");

  a_reset_keep: assert property ((sys_reset_hold && !wr_sig_run) |=> sys_reset_hold)
    else $error("held system reset dropped without run signature");

  a_rsv_no_hold: assert property ((!sys_reset_hold && !wr_sig_reset) |=> !sys_reset_hold)
    else $error("system reset held without reset signature");

  a_reset_release: assert property (wr_sig_run |=> !sys_reset_hold)
    else $error("run signature did not release system reset");

  a_urow_start: assert property (userrow_prog_start |->
    $past(wr_ctrl && userrow_key_ok && wr_byte[CTRL_UROW_DONE_BIT]))
    else $error("user row programming started without keyed write");

  a_urow_keyless: assert property ((wr_ctrl && !userrow_key_ok) |=> !userrow_prog_start)
    else $error("user row programming started without key");

  a_ro_no_effect: assert property ((wr_go && dbg_enable && (wr_idx == IDX_SYS_STATUS[3:0])) |=>
    $stable({clk_req_r, urow_done_r, reset_req_r}))
    else $error("write to status register changed control state");

  a_ro_write_ok: assert property ((wr_go && (wr_idx == IDX_SYS_STATUS[3:0])) |=>
    (s_axi_bvalid && s_axi_bresp == RESP_OKAY))
    else $error("write to status register not answered okay");

  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
  c_status_read: cover property (rd_status ##1 s_axi_rvalid);
  c_crc_fail: cover property (crc_field == CRC_CODE_FAIL);
  c_reset_cycle: cover property (wr_sig_reset ##[1:20] wr_sig_run);
  c_boot_open: cover property ($rose(bridge_access_allow));

endmodule
`default_nettype wire

/* File: bench/dbgst_sys_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dbgst_sys_model #(
  parameter int BOOT_DLY = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Requests from the debug side
  input wire logic sys_reset_hold,
  input wire logic erase_cmd,
  // System state
  output logic sys_in_reset,
  output logic cpu_boot_done,
  output logic erase_fail_evt
);
  logic [7:0] boot_cnt_r;

  // The system only boots once a held reset is let go, as real silicon does
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sys_in_reset <= 1'b0;
      cpu_boot_done <= 1'b0;
      erase_fail_evt <= 1'b0;
      boot_cnt_r <= 8'h00;
    end else begin
      sys_in_reset <= sys_reset_hold;
      erase_fail_evt <= erase_cmd;
      cpu_boot_done <= 1'b0;
      if (sys_in_reset && !sys_reset_hold) begin
        boot_cnt_r <= 8'(BOOT_DLY);
      end else if (boot_cnt_r != 8'h00) begin
        boot_cnt_r <= boot_cnt_r - 8'h01;
        cpu_boot_done <= (boot_cnt_r == 8'h01);
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/debug_port_system_status_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module debug_port_system_status_tb_top;
  import dbgst_pkg::*;
  logic ref_clk, reset_n;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic dbg_enable, userrow_key_ok, sys_in_reset, cpu_boot_done, erase_fail_evt, erase_cmd;
  logic [2:0] sys_sleep_mode;
  logic nvm_prog_ok, userrow_prog_ok, nvm_lock_bits, crc_enabled, crc_done, crc_pass;
  logic sys_clock_request, sys_reset_hold, userrow_prog_start, bridge_access_allow;
  int mismatches, tests_run, starts, s;

  dbgst_top DUT (.ref_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .dbg_enable, .userrow_key_ok, .sys_in_reset, .sys_sleep_mode, .cpu_boot_done,
    .erase_fail_evt, .nvm_prog_ok, .userrow_prog_ok, .nvm_lock_bits, .crc_enabled, .crc_done,
    .crc_pass, .sys_clock_request, .sys_reset_hold, .userrow_prog_start, .bridge_access_allow);

  dbgst_sys_model #(.BOOT_DLY(4)) sys_model (.ref_clk, .reset_n, .sys_reset_hold, .erase_cmd,
    .sys_in_reset, .cpu_boot_done, .erase_fail_evt);

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (userrow_prog_start === 1'b1) starts++;
  end

  task automatic wrap_up;
    if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic give_up;
    mismatches++;
    wrap_up();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask

  // Status byte built from the individual flags; bit 7 is derived, never passed in
  function automatic logic [31:0] st(input logic ef, rst, slp, pg, ur, bd, lk);
    return {24'h0, ef | bd, ef, rst, slp, pg, ur, bd, lk};
  endfunction

  task automatic axi_wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= {idx[3:0], 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (n > 100) give_up();
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
    // Let registered side effects land before anyone looks at the outputs
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic axi_rd(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= {idx[3:0], 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (n > 100) give_up();
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk(32'(s_axi_rresp), 32'(er));
  endtask

  initial begin
    reset_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 6'h00;
    s_axi_araddr = 6'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {dbg_enable, userrow_key_ok, erase_cmd, sys_sleep_mode} = 6'h20;
    {nvm_prog_ok, userrow_prog_ok, nvm_lock_bits} = 3'h1;
    {crc_enabled, crc_done, crc_pass} = 3'h0;
    mismatches = 0;
    tests_run = 0;
    starts = 0;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    axi_rd(IDX_SYS_STATUS, st(0, 0, 0, 0, 0, 0, 1));
    axi_rd(IDX_CRC_STATUS, 32'h0);
    chk(32'(sys_clock_request), 32'h1);
    chk(32'(bridge_access_allow), 32'h0);
    axi_wr(IDX_SYS_STATUS, 32'hff);
    axi_wr(IDX_CRC_STATUS, 32'hff);
    axi_rd(IDX_SYS_STATUS, st(0, 0, 0, 0, 0, 0, 1));
    axi_rd(IDX_CRC_STATUS, 32'h0);
    axi_wr(8'h0f, 32'h1, RESP_SLVERR);
    axi_rd(8'h0f, 32'h0, RESP_SLVERR);
    // Clock request must follow the bit even with the system asleep
    sys_sleep_mode <= 3'h3;
    axi_wr(IDX_SYS_CTRL, 32'h0);
    chk(32'(sys_clock_request), 32'h0);
    axi_wr(IDX_SYS_CTRL, 32'h1);
    chk(32'(sys_clock_request), 32'h1);
    axi_rd(IDX_SYS_STATUS, st(0, 0, 1, 0, 0, 0, 1));
    sys_sleep_mode <= 3'h0;
    axi_wr(IDX_SYS_CTRL, 32'h0);
    dbg_enable <= 1'b0;
    repeat (2) @(posedge ref_clk);
    dbg_enable <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(32'(sys_clock_request), 32'h1);
    for (int i = 0; i < 8; i++) begin
      {nvm_prog_ok, userrow_prog_ok, nvm_lock_bits} <= i[2:0];
      axi_rd(IDX_SYS_STATUS, st(0, 0, 0, i[2], i[1], 0, i[0]));
    end
    {nvm_prog_ok, userrow_prog_ok, nvm_lock_bits} <= 3'h1;
    erase_cmd <= 1'b1;
    @(posedge ref_clk);
    erase_cmd <= 1'b0;
    axi_rd(IDX_SYS_STATUS, st(1, 0, 0, 0, 0, 0, 1));
    axi_wr(IDX_RESET_REQ, 32'h33);
    chk(32'(sys_reset_hold), 32'h0);
    axi_wr(IDX_RESET_REQ, 32'h59);
    chk(32'(sys_reset_hold), 32'h1);
    axi_rd(IDX_RESET_REQ, 32'h59);
    axi_rd(IDX_SYS_STATUS, st(0, 1, 0, 0, 0, 0, 1));
    axi_rd(IDX_SYS_STATUS, st(0, 1, 0, 0, 0, 0, 1));
    // Reserved values are stored but leave the held reset alone
    axi_wr(IDX_RESET_REQ, 32'h33);
    chk(32'(sys_reset_hold), 32'h1);
    axi_rd(IDX_RESET_REQ, 32'h33);
    axi_wr(IDX_RESET_REQ, 32'h00);
    chk(32'(sys_reset_hold), 32'h0);
    s = 0;
    while (bridge_access_allow !== 1'b1) begin
      @(posedge ref_clk);
      s++;
      if (s > 60) give_up();
    end
    axi_rd(IDX_SYS_STATUS, st(0, 1, 0, 0, 0, 1, 1));
    axi_rd(IDX_SYS_STATUS, st(0, 0, 0, 0, 0, 1, 1));
    // A user-row commit without the key must not start programming
    s = starts;
    axi_wr(IDX_SYS_CTRL, 32'h3);
    chk(32'(starts), 32'(s));
    userrow_key_ok <= 1'b1;
    axi_wr(IDX_SYS_CTRL, 32'h3);
    chk(32'(starts), 32'(s + 1));
    chk(32'(sys_clock_request), 32'h1);
    // Lane 0 disabled: the control byte must not move
    s_axi_wstrb <= 4'he;
    axi_wr(IDX_SYS_CTRL, 32'h0);
    chk(32'(sys_clock_request), 32'h1);
    s_axi_wstrb <= 4'hf;
    for (int p = 0; p < 2; p++) begin
      crc_enabled <= 1'b1;
      crc_pass <= p[0];
      axi_rd(IDX_CRC_STATUS, 32'h1);
      crc_done <= 1'b1;
      @(posedge ref_clk);
      crc_done <= 1'b0;
      axi_rd(IDX_CRC_STATUS, p[0] ? 32'h2 : 32'h4);
      crc_enabled <= 1'b0;
      axi_rd(IDX_CRC_STATUS, 32'h0);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
